// File: bench/eac_ctrl_asserts.sv
// Port checker for the EEPROM access controller.
// Assumes one ref_clk domain and a synchronous active-high reset.
`timescale 1ns/1ns
module eac_ctrl_asserts
(
  // Clock and reset
  input logic       ref_clk,
  input logic       sys_rst,
  // Register port
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  // Core and power
  input logic       sleep_pd,
  input logic       cpu_stall,
  input logic       osc_run,
  input logic       ready_irq,
  input logic       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ========
  // Properties
  a_stall_cause: assert property ($rose(cpu_stall) |->
    $past(reg_wr && reg_addr == 4'h3 && reg_wdata[0])) else $error("bad stall");
  a_stall_four: assert property ($rose(cpu_stall) |->
    cpu_stall[*4] ##1 !cpu_stall) else $error("stall length");
  a_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 8'h00) else $error("rdata not idle");
  a_strobe_zero: assert property ($past(reg_rd && reg_addr == 4'h3) |->
    reg_rdata[0] == 1'b0 && reg_rdata[7:4] == 4'h0) else $error("read bit");
  a_ready_level: assert property ($past(reg_rd && reg_addr == 4'h3) |->
    (reg_rdata[3] && !reg_rdata[1]) == $past(ready_irq)) else $error("ready");
  a_osc_busy: assert property ($past(reg_rd && reg_addr == 4'h3) &&
    reg_rdata[1] |-> $past(osc_run)) else $error("osc stopped in write");
  a_osc_awake: assert property (!sleep_pd |-> osc_run)
    else $error("osc off awake");
  a_osc_hold: assert property (sleep_pd && $past(sleep_pd) &&
    $past(osc_run) |-> osc_run) else $error("osc stopped after write");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    reg_rdata == 8'h00 && !cpu_stall) else $error("reset outputs");
  a_reset_irq: assert property (disable iff (1'b0) sys_rst |=>
    !irq && !ready_irq) else $error("reset irq");
endmodule // eac_ctrl_asserts

bind eac_ctrl eac_ctrl_asserts u_chk
(
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sleep_pd(sleep_pd), .cpu_stall(cpu_stall),
  .osc_run(osc_run), .ready_irq(ready_irq), .irq(irq)
);

// File: bench/testbench.sv
// Directed testbench for the EEPROM access controller.
// Assumes eac_ctrl with a short write count of four oscillator ticks.
`timescale 1ns/1ns
module testbench;
  logic       ref_clk   = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       sleep_pd  = 1'b0;
  wire  [7:0] reg_rdata;
  wire        cpu_stall;
  wire        osc_run;
  wire        ready_irq;
  wire        irq;
  int         n_errors  = 0;
  int         compares  = 0;
  int         n;
  logic [7:0] d;

  always #5 ref_clk = ~ref_clk;

  eac_ctrl #(.WR_OSC_CYC(4)) uut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_pd(sleep_pd), .cpu_stall(cpu_stall),
    .osc_run(osc_run), .ready_irq(ready_irq), .irq(irq)
  );

  // ========
  // Access and compare tasks
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask

  task rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask

  // Polls the write bit, two cycles a poll
  task wait_idle;
    n = 0;
    d = 8'h02;
    while (d[1] !== 1'b0 && n < 300)
    begin
      rd(4'h3);
      n++;
    end
  endtask

  task finish_test;
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ========
  // Tests
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdc(4'h3, 8'h00);
    wr(4'h1, 8'hFF);
    rdc(4'h1, 8'h03);
    wr(4'h7, 8'h5A);
    rdc(4'h7, 8'h00);
    wr(4'h3, 8'h02);
    rdc(4'h3, 8'h00);
    wr(4'h3, 8'h04);
    rdc(4'h3, 8'h04);
    repeat (2) @(posedge ref_clk);
    rdc(4'h3, 8'h00);
    wr(4'h3, 8'h02);
    rdc(4'h3, 8'h00);
    // Armed write at the last cycle of the window
    wr(4'h0, 8'hA5);
    wr(4'h1, 8'h02);
    wr(4'h2, 8'h5C);
    wr(4'h3, 8'h0C);
    repeat (2) @(posedge ref_clk);
    wr(4'h3, 8'h0A);
    rdc(4'h3, 8'h0A);
    chk({7'h00, ready_irq}, 8'h00);
    wr(4'h0, 8'h11);
    wr(4'h2, 8'h77);
    rdc(4'h0, 8'hA5);
    rdc(4'h2, 8'h5C);
    wr(4'h3, 8'h09);
    chk({7'h00, cpu_stall}, 8'h00);
    wait_idle;
    chk({7'h00, n >= 140 && n <= 197}, 8'h01);
    chk({7'h00, ready_irq}, 8'h01);
    rdc(4'h3, 8'h08);
    wr(4'h5, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(4'h5, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rdc(4'h4, 8'h05);
    rdc(4'h4, 8'h00);
    // Read back through the read strobe
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h02);
    wr(4'h3, 8'h01);
    chk({7'h00, cpu_stall}, 8'h01);
    @(posedge ref_clk);
    rdc(4'h2, 8'h5C);
    chk({7'h00, irq}, 8'h01);
    rdc(4'h4, 8'h02);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, cpu_stall}, 8'h00);
    // Reset and power-down in mid-write
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h3C);
    wr(4'h3, 8'h04);
    wr(4'h3, 8'h02);
    sleep_pd <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk({7'h00, osc_run}, 8'h01);
    wait_idle;
    chk({7'h00, n > 10 && n < 300}, 8'h01);
    chk({7'h00, osc_run}, 8'h01);
    sleep_pd <= 1'b0;
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h01);
    @(posedge ref_clk);
    rdc(4'h2, 8'h3C);
    sleep_pd <= 1'b1;
    @(posedge ref_clk);
    chk({7'h00, osc_run}, 8'h00);
    finish_test;
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    finish_test;
  end
endmodule // testbench

// File: logic/eac_array.v
// Byte-wide nonvolatile array model built from flip-flops.
// Assumes one write or one read per cycle; read data one cycle later.
// The array holds its contents over reset.
`timescale 1ns/1ns
`include "eac_map.vh"

module eac_array
(
  // Clock
  input  wire                 ref_clk,
  // Access port
  input  wire [`EAC_AW-1:0]   arr_addr,
  input  wire                 arr_we,
  input  wire [7:0]           arr_wdata,
  output reg  [7:0]           arr_rdata
);

  reg [7:0] mem_reg [0:`EAC_DEPTH-1];

  // =====================================================================
  // Storage and registered read
  always @(posedge ref_clk)
  begin
    if (arr_we)
      mem_reg[arr_addr] <= arr_wdata;
    arr_rdata <= mem_reg[arr_addr];
  end

endmodule // eac_array

// File: logic/eac_ctrl.v
// EEPROM access controller: address, data, control and event registers,
// read with CPU stall, armed write timed by the 1 MHz oscillator tick.
// Assumes a CPU master on the plain register port and a cpu_stall input
// on the core that holds instruction execution while high.
//
// Overview of operation
// RULE1 - A one written to the read strobe loads the data register from the array at the held address.
// RULE2 - Each read holds the processor stalled for four cycles.
// RULE3 - During a write, read strobes are dropped and address writes are ignored.
// RULE4 - Software checks the write strobe is zero before starting a read.
// RULE5 - A CPU write lasts 8448 oscillator cycles, about 8.5 ms.
// RULE6 - Write timing always uses the fixed 1 MHz oscillator tick, whatever clock source is fused.
// RULE7 - A write running at power-down entry completes; the oscillator keeps running after.
// RULE8 - Software confirms write completion before asking for power-down.
// RULE9 - A reset during a write does not abort it; the write still completes.
// RULE10 - Software waits for any flash self-program command before starting a write.
// RULE11 - Software waits idle, loads address and data, sets the arm bit, then the write strobe.
// RULE12 - The write strobe starts a write only within four cycles of the arm bit being set.
// RULE13 - The arm bit clears itself four cycles after software sets it.
// RULE14 - The write strobe bit clears when the write time has elapsed.
// RULE15 - With the ready enable set, a ready request stands while the write strobe is clear.
// RULE16 - The read strobe bit is a one-shot and always reads back zero once done.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "eac_map.vh"

module eac_ctrl
#(
  parameter WR_OSC_CYC = `EAC_WR_OSC_CYC
)
(
  // Clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Core and power
  input  wire       sleep_pd,
  output wire       cpu_stall,
  output wire       osc_run,
  output wire       ready_irq,
  output wire       irq
);

  // States of the write sequencer
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PROG = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  localparam integer WR_LAST_I    = WR_OSC_CYC - 1;
  localparam integer ARM_LAST_I   = `EAC_ARM_CYC - 1;
  localparam integer STALL_LAST_I = `EAC_RD_STALL_CYC - 1;
  localparam [13:0]  WR_LAST      = WR_LAST_I[13:0];
  localparam [2:0]   ARM_LAST     = ARM_LAST_I[2:0];
  localparam [2:0]   STALL_LAST   = STALL_LAST_I[2:0];

  reg [`EAC_AW-1:0] nv_address_reg;
  reg [7:0]         nv_data_reg;
  reg               ready_irq_enable;
  reg               write_arm_bit;
  reg [2:0]         arm_cnt_reg;
  reg [2:0]         state_reg;
  reg [2:0]         state_next;
  reg [13:0]        osc_cnt_reg;
  reg               rd_pend_reg;
  reg [2:0]         stall_cnt_reg;
  reg               stall_reg;
  reg [2:0]         ev_stat_reg;
  reg [2:0]         ev_mask_reg;
  reg [7:0]         rdata_next;
  reg [`EAC_AW-1:0] wr_addr_reg;
  reg [7:0]         wr_data_reg;
  reg               osc_hold_reg;

  wire       osc_tick;
  wire [7:0] arr_rdata;
  wire       write_strobe_bit;
  wire       wr_busy;
  wire       ctrl_wr;
  wire       start_wr;
  wire       rd_req;
  wire       rd_lost;
  wire       arr_we;
  wire [2:0] ev_set;
  wire [`EAC_AW-1:0] arr_addr;

  // =====================================================================
  // Oscillator tick and array
  eac_osc_tick u_tick
  (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .osc_tick (osc_tick)
  );

  eac_array u_array
  (
    .ref_clk   (ref_clk),
    .arr_addr  (arr_addr),
    .arr_we    (arr_we),
    .arr_wdata (wr_data_reg),
    .arr_rdata (arr_rdata)
  );

  assign wr_busy          = (state_reg == ST_PROG);
  assign write_strobe_bit = wr_busy;
  assign ctrl_wr          = reg_wr && (reg_addr == `EAC_OFF_CTRL);
  assign start_wr         = ctrl_wr && reg_wdata[`EAC_CTRL_WRITE]
                            && write_arm_bit && !wr_busy; // RULE12
  assign rd_req           = ctrl_wr && reg_wdata[`EAC_CTRL_READ];
  assign rd_lost          = rd_req && wr_busy; // RULE3
  assign arr_we           = wr_busy && osc_tick && (osc_cnt_reg == WR_LAST);

  // =====================================================================
  // Write sequencer, reset by sys_rst only outside a write so a running write finishes
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_wr)
          state_next = ST_PROG;
      ST_PROG:
        if (arr_we)
          state_next = ST_DONE; // RULE5 RULE6 RULE14
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  initial state_reg = ST_IDLE;
  initial osc_cnt_reg = 14'h0000;

  always @(posedge ref_clk)
  begin
    // RULE9 RULE7
    if (sys_rst && !wr_busy)
    begin
      state_reg   <= ST_IDLE;
      osc_cnt_reg <= 14'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (start_wr)
        osc_cnt_reg <= 14'h0000;
      else if (wr_busy && osc_tick)
        osc_cnt_reg <= osc_cnt_reg + 14'h0001; // RULE5 RULE6
    end
  end

  // =====================================================================
  // Write target, captured at the start and kept over sys_rst
  always @(posedge ref_clk)
  begin
    if (start_wr)
    begin
      wr_addr_reg <= nv_address_reg; // RULE9
      wr_data_reg <= nv_data_reg; // RULE9
    end
  end

  // Array addressed by the write target while busy
  assign arr_addr = wr_busy ? wr_addr_reg : nv_address_reg;

  // Oscillator kept running through a write, and after one ends in sleep
  initial osc_hold_reg = 1'b0;

  always @(posedge ref_clk)
  begin
    if (!sleep_pd)
      osc_hold_reg <= 1'b0;
    else if (wr_busy)
      osc_hold_reg <= 1'b1; // RULE7
  end

  assign osc_run = wr_busy || !sleep_pd || osc_hold_reg; // RULE7

  // =====================================================================
  // Address and control bits
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      nv_address_reg   <= `EAC_ADDR_RST;
      ready_irq_enable <= 1'b0;
      write_arm_bit    <= 1'b0;
      arm_cnt_reg      <= 3'h0;
    end
    else
    begin
      if (reg_wr && !wr_busy && reg_addr == `EAC_OFF_ADDR_LO)
        nv_address_reg[7:0] <= reg_wdata; // RULE3
      if (reg_wr && !wr_busy && reg_addr == `EAC_OFF_ADDR_HI)
        nv_address_reg[9:8] <= reg_wdata[1:0]; // RULE3
      if (ctrl_wr)
        ready_irq_enable <= reg_wdata[`EAC_CTRL_RDY_IE];
      if (ctrl_wr && reg_wdata[`EAC_CTRL_ARM]
          && !reg_wdata[`EAC_CTRL_WRITE])
      begin
        write_arm_bit <= 1'b1;
        arm_cnt_reg   <= 3'h0;
      end
      else if (start_wr)
        write_arm_bit <= 1'b0;
      else if (write_arm_bit)
      begin
        arm_cnt_reg <= arm_cnt_reg + 3'h1;
        if (arm_cnt_reg == ARM_LAST)
          write_arm_bit <= 1'b0; // RULE13
      end
    end
  end

  // =====================================================================
  // Read with stall
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      nv_data_reg   <= `EAC_DATA_RST;
      rd_pend_reg   <= 1'b0;
      stall_reg     <= 1'b0;
      stall_cnt_reg <= 3'h0;
    end
    else
    begin
      rd_pend_reg <= rd_req && !wr_busy; // RULE1 RULE16
      if (rd_pend_reg)
        nv_data_reg <= arr_rdata; // RULE1
      else if (reg_wr && reg_addr == `EAC_OFF_DATA && !wr_busy)
        nv_data_reg <= reg_wdata;
      if (rd_req && !wr_busy)
      begin
        stall_reg     <= 1'b1; // RULE2
        stall_cnt_reg <= 3'h0;
      end
      else if (stall_reg)
      begin
        stall_cnt_reg <= stall_cnt_reg + 3'h1;
        if (stall_cnt_reg == STALL_LAST)
          stall_reg <= 1'b0; // RULE2
      end
    end
  end

  assign cpu_stall = stall_reg;

  // =====================================================================
  // Ready request and event interrupt
  assign ready_irq = ready_irq_enable && !write_strobe_bit; // RULE15

  assign ev_set = {rd_lost, rd_pend_reg, state_reg == ST_DONE};

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ev_stat_reg <= 3'h0;
      ev_mask_reg <= `EAC_MASK_RST;
    end
    else
    begin
      if (reg_rd && reg_addr == `EAC_OFF_IRQ_STAT)
        ev_stat_reg <= ev_set;
      else
        ev_stat_reg <= ev_stat_reg | ev_set;
      if (reg_wr && reg_addr == `EAC_OFF_IRQ_MASK)
        ev_mask_reg <= reg_wdata[2:0];
    end
  end

  assign irq = |(ev_stat_reg & ev_mask_reg);

  // =====================================================================
  // Read data, one cycle after the strobe
  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `EAC_OFF_ADDR_LO:  rdata_next = nv_address_reg[7:0];
      `EAC_OFF_ADDR_HI:  rdata_next = {6'h00, nv_address_reg[9:8]};
      `EAC_OFF_DATA:     rdata_next = nv_data_reg;
      `EAC_OFF_CTRL:     rdata_next = {4'h0, ready_irq_enable,
                                       write_arm_bit, write_strobe_bit,
                                       1'b0}; // RULE16
      `EAC_OFF_IRQ_STAT: rdata_next = {5'h00, ev_stat_reg};
      `EAC_OFF_IRQ_MASK: rdata_next = {5'h00, ev_mask_reg};
      default:           rdata_next = 8'h00;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 8'h00;
  end

endmodule // eac_ctrl

// File: logic/eac_map.vh
// Constants for the EEPROM access controller: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the logic/ files.
`ifndef EAC_MAP_VH
`define EAC_MAP_VH

// =====================================================================
// Register offsets (plain register port, byte-wide data)
`define EAC_OFF_ADDR_LO   4'h0
`define EAC_OFF_ADDR_HI   4'h1
`define EAC_OFF_DATA      4'h2
`define EAC_OFF_CTRL      4'h3
`define EAC_OFF_IRQ_STAT  4'h4
`define EAC_OFF_IRQ_MASK  4'h5

// =====================================================================
// Control register fields
`define EAC_CTRL_READ     0
`define EAC_CTRL_WRITE    1
`define EAC_CTRL_ARM      2
`define EAC_CTRL_RDY_IE   3

// Event status fields
`define EAC_EV_WR_DONE    0
`define EAC_EV_RD_DONE    1
`define EAC_EV_STRB_LOST  2

// =====================================================================
// Sizes and reset values
`define EAC_AW            10
`define EAC_DEPTH         1024
`define EAC_ADDR_RST      10'h000
`define EAC_DATA_RST      8'h00
`define EAC_MASK_RST      3'h0

// =====================================================================
// Timing
`define EAC_CLK_MHZ       100
`define EAC_OSC_MHZ       1
`define EAC_OSC_DIV       (`EAC_CLK_MHZ / `EAC_OSC_MHZ)
`define EAC_WR_OSC_CYC    8448
`define EAC_WR_TIME_US    8500
`define EAC_ARM_CYC       4
`define EAC_RD_STALL_CYC  4

`endif

// File: logic/eac_osc_tick.v
// Divider that makes the 1 MHz calibrated oscillator tick.
// Assumes the 100 MHz ref_clk; the output is a one-cycle enable pulse.
`timescale 1ns/1ns
`include "eac_map.vh"

module eac_osc_tick
(
  // Clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // Tick out
  output reg        osc_tick
);

  localparam integer DIV_LAST_I = `EAC_OSC_DIV - 1;
  localparam [6:0]   DIV_LAST   = DIV_LAST_I[6:0];

  reg [6:0] div_reg;

  // =====================================================================
  // Free-running divider, never halted by sleep
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      div_reg  <= 7'h00;
      osc_tick <= 1'b0;
    end
    else
    begin
      osc_tick <= (div_reg == DIV_LAST);
      if (div_reg == DIV_LAST)
        div_reg <= 7'h00;
      else
        div_reg <= div_reg + 7'h01;
    end
  end

endmodule // eac_osc_tick
